// ---- rtl/irq_flag_regs.sv ----
// interrupt flag status register with apb slave and interrupt output
// Operation
// RL1 - flags read/write, zero after reset
// RL2 - fixed bit positions for each source
// RL3 - flag set by request until cleared
// RL4 - uart receive sets bit eleven only
// RL5 - external zero edge sets bit zero
// RL6 - bits 15,14,4 zero; flags stay set
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_map.svh"
module irq_flag_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire irq_flag_pkg::bus_addr_type paddr,
  input wire irq_flag_pkg::bus_word_type pwdata,
  input wire logic [3:0] pstrb,
  output irq_flag_pkg::bus_word_type prdata,
  output logic pready,
  output logic pslverr,
  // peripheral request pulses, same clock
  input wire logic converter_req,
  input wire logic uart_first_tx_req,
  input wire logic uart_first_rx_req,
  input wire logic spi_first_event_req,
  input wire logic spi_first_fault_req,
  input wire logic timer_three_req,
  input wire logic timer_two_req,
  input wire logic compare_two_req,
  input wire logic capture_two_req,
  input wire logic timer_one_req,
  input wire logic compare_one_req,
  input wire logic capture_one_req,
  // external interrupt pin and polarity
  input wire logic external_zero_pin,
  input wire logic external_zero_fall,
  // interrupt output
  output logic irq
);
  import irq_flag_pkg::*;

  flag_word_type flag_ff;
  flag_word_type nxt_flag;
  flag_word_type irq_status_ff;
  flag_word_type nxt_irq_status;
  flag_word_type irq_mask_ff;
  flag_word_type nxt_irq_mask;
  flag_word_type req_vec;
  flag_word_type wr_data;
  flag_word_type wr_lanes;
  bus_word_type prdata_ff;
  bus_word_type nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic ext_edge;
  logic access;
  logic wr_en;
  logic known_addr;

  // external pin synchronised and edge detected
  edge_sync u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_zero_pin),
    .fall_sel(external_zero_fall),
    .edge_pulse(ext_edge)
  );

  // RL2 source bit mapping
  always_comb begin
    req_vec = '0;
    req_vec[`BIT_CONVERTER] = converter_req;
    req_vec[`BIT_UART_TX] = uart_first_tx_req;
    // RL4 receive on own bit
    req_vec[`BIT_UART_RX] = uart_first_rx_req;
    req_vec[`BIT_SPI_EVENT] = spi_first_event_req;
    req_vec[`BIT_SPI_FAULT] = spi_first_fault_req;
    req_vec[`BIT_TIMER_THREE] = timer_three_req;
    req_vec[`BIT_TIMER_TWO] = timer_two_req;
    req_vec[`BIT_COMPARE_TWO] = compare_two_req;
    req_vec[`BIT_CAPTURE_TWO] = capture_two_req;
    req_vec[`BIT_TIMER_ONE] = timer_one_req;
    req_vec[`BIT_COMPARE_ONE] = compare_one_req;
    req_vec[`BIT_CAPTURE_ONE] = capture_one_req;
    // RL5 external edge to bit zero
    req_vec[`BIT_EXTERNAL_ZERO] = ext_edge;
  end

  // apb decode, zero wait states
  assign access = psel & penable;
  assign wr_en = access & pwrite;
  assign known_addr = (paddr == `OFS_FLAG_STATUS) |
                      (paddr == `OFS_IRQ_STATUS) |
                      (paddr == `OFS_IRQ_MASK);
  assign wr_data = pwdata[15:0];
  assign wr_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // next values of the three registers
  always_comb begin
    nxt_flag = flag_ff;
    nxt_irq_status = irq_status_ff;
    nxt_irq_mask = irq_mask_ff;
    // RL1 software writes the flags
    if (wr_en && paddr == `OFS_FLAG_STATUS) begin
      nxt_flag = (flag_ff & ~wr_lanes) | (wr_data & wr_lanes);
    end
    if (wr_en && paddr == `OFS_IRQ_MASK) begin
      nxt_irq_mask = (irq_mask_ff & ~wr_lanes) | (wr_data & wr_lanes);
    end
    if (wr_en && paddr == `OFS_IRQ_STATUS) begin
      nxt_irq_status = irq_status_ff & ~(wr_data & wr_lanes);
    end
    // RL3 request sets, set beats clear
    nxt_flag = nxt_flag | req_vec;
    nxt_irq_status = nxt_irq_status | req_vec;
    // RL6 unimplemented bits held zero
    nxt_flag = nxt_flag & `FLAG_IMPL_MASK;
    nxt_irq_mask = nxt_irq_mask & `FLAG_IMPL_MASK;
    nxt_irq_status = nxt_irq_status & `FLAG_IMPL_MASK;
  end

  // read data and error response
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && !penable) begin
      nxt_prdata = '0;
      unique case (paddr)
        `OFS_FLAG_STATUS: nxt_prdata = {16'h0000, flag_ff};
        `OFS_IRQ_STATUS: nxt_prdata = {16'h0000, irq_status_ff};
        `OFS_IRQ_MASK: nxt_prdata = {16'h0000, irq_mask_ff};
        default: nxt_prdata = '0;
      endcase
      nxt_pslverr = ~known_addr;
    end
  end

  // register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RL1 zero after reset
      flag_ff <= `FLAG_RESET;
      irq_status_ff <= `IRQ_STATUS_RESET;
      irq_mask_ff <= `IRQ_MASK_RESET;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = access & pslverr_ff;
  assign irq = |(irq_status_ff & irq_mask_ff);

  property p_req_sets; // RL3
    @(posedge pclk) disable iff (!presetn)
      timer_two_req |=> flag_ff[`BIT_TIMER_TWO];
  endproperty
  a_req_sets: assert property (p_req_sets) // RL3
    else $error("timer two request did not set flag");

  property p_rx_own_bit; // RL4
    @(posedge pclk) disable iff (!presetn)
      (uart_first_rx_req && !uart_first_tx_req && !flag_ff[`BIT_UART_TX]
       && !wr_en) |=> flag_ff[`BIT_UART_RX] && !flag_ff[`BIT_UART_TX];
  endproperty
  a_rx_own_bit: assert property (p_rx_own_bit) // RL4
    else $error("receive request touched wrong bit");

  property p_ext_edge; // RL5
    @(posedge pclk) disable iff (!presetn)
      (!external_zero_fall && $rose(external_zero_pin)) ##2
      !external_zero_fall |=> flag_ff[`BIT_EXTERNAL_ZERO];
  endproperty
  a_ext_edge: assert property (p_ext_edge) // RL5
    else $error("external edge did not set bit zero");

  // falling polarity, same two-stage latency
  property p_ext_fall; // RL5
    @(posedge pclk) disable iff (!presetn)
      (external_zero_fall && $fell(external_zero_pin)) ##2
      external_zero_fall |=> flag_ff[`BIT_EXTERNAL_ZERO];
  endproperty
  a_ext_fall: assert property (p_ext_fall) // RL5
    else $error("falling external edge did not set bit zero");

  property p_unimpl_zero; // RL6
    @(posedge pclk) disable iff (!presetn)
      (flag_ff & ~`FLAG_IMPL_MASK) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // RL6
    else $error("unimplemented flag bit set");

  property p_sticky; // RL6
    @(posedge pclk) disable iff (!presetn)
      (flag_ff[`BIT_CONVERTER] && !wr_en) |=> flag_ff[`BIT_CONVERTER];
  endproperty
  a_sticky: assert property (p_sticky) // RL6
    else $error("flag dropped without software write");

  property p_sw_write; // RL1
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFS_FLAG_STATUS && pstrb[1] && req_vec == '0)
      |=> flag_ff[15:8] == ($past(pwdata[15:8]) & 8'h3f);
  endproperty
  a_sw_write: assert property (p_sw_write) // RL1
    else $error("software write to flags not stored");

  property p_no_spurious; // RL3
    @(posedge pclk) disable iff (!presetn)
      (!flag_ff[`BIT_TIMER_ONE] && !timer_one_req && !wr_en)
      |=> !flag_ff[`BIT_TIMER_ONE];
  endproperty
  a_no_spurious: assert property (p_no_spurious) // RL3
    else $error("flag set without request");

  property p_map_compare; // RL2
    @(posedge pclk) disable iff (!presetn)
      compare_one_req |=> flag_ff[2];
  endproperty
  a_map_compare: assert property (p_map_compare) // RL2
    else $error("compare one not at bit two");
endmodule
`default_nettype wire

// ---- pkg/irq_flag_map.svh ----
// register offsets, field positions and reset values of the flag block
`ifndef IRQ_FLAG_MAP_SVH
`define IRQ_FLAG_MAP_SVH
`define OFS_FLAG_STATUS 12'h000
`define OFS_IRQ_STATUS 12'h004
`define OFS_IRQ_MASK 12'h008
`define FLAG_WIDTH 16
`define FLAG_IMPL_MASK 16'h3fef
`define FLAG_RESET 16'h0000
`define IRQ_STATUS_RESET 16'h0000
`define IRQ_MASK_RESET 16'h0000
`define BIT_CONVERTER 13
`define BIT_UART_TX 12
`define BIT_UART_RX 11
`define BIT_SPI_EVENT 10
`define BIT_SPI_FAULT 9
`define BIT_TIMER_THREE 8
`define BIT_TIMER_TWO 7
`define BIT_COMPARE_TWO 6
`define BIT_CAPTURE_TWO 5
`define BIT_TIMER_ONE 3
`define BIT_COMPARE_ONE 2
`define BIT_CAPTURE_ONE 1
`define BIT_EXTERNAL_ZERO 0
`endif

// ---- pkg/irq_flag_pkg.sv ----
// types shared by the flag block
package irq_flag_pkg;
  typedef logic [15:0] flag_word_type;
  typedef logic [31:0] bus_word_type;
  typedef logic [11:0] bus_addr_type;
endpackage

// ---- rtl/edge_sync.sv ----
// two-stage synchroniser with rising or falling edge detection
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side
  input wire logic pin_in,
  input wire logic fall_sel,
  // detected edge, one cycle
  output logic edge_pulse
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  // next state of the shift chain
  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  // register the chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // edge of selected polarity
  assign edge_pulse = fall_sel ? (prev_ff & ~sync_ff) : (~prev_ff & sync_ff);
endmodule
`default_nettype wire

// ---- test/irq_source_model.sv ----
// peripheral request sources driving the flag block
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // one-cycle commands from the bench, bit 12 toggles the pin
  input wire logic [12:0] fire,
  // request pulses and external pin
  output logic [11:0] req,
  output logic ext_pin
);
  // one-cycle request pulses, pin toggles on command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 12'h000;
      ext_pin <= 1'b0;
    end else begin
      req <= fire[11:0];
      if (fire[12]) ext_pin <= ~ext_pin;
    end
  end
endmodule
`default_nettype wire

// ---- test/irq_flag_regs_tb.sv ----
// self-checking bench for the flag register block
`timescale 1ns/1ps
`default_nettype none
`include "irq_flag_map.svh"
module irq_flag_regs_tb;
  import irq_flag_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq;
  logic pready, pslverr, ext_pin, err_seen, ext_fall = 0;
  bus_addr_type paddr = 12'h000;
  bus_word_type pwdata = 32'h0, prdata, rd;
  logic [12:0] fire = 13'h0000;
  logic [11:0] req;
  int error_cnt = 0, checked = 0, cyc = 0;
  int pos [12] = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13};
  irq_flag_regs u_irq_flag_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_one_req(req[0]), .compare_one_req(req[1]),
    .timer_one_req(req[2]), .capture_two_req(req[3]),
    .compare_two_req(req[4]), .timer_two_req(req[5]),
    .timer_three_req(req[6]), .spi_first_fault_req(req[7]),
    .spi_first_event_req(req[8]), .uart_first_rx_req(req[9]),
    .uart_first_tx_req(req[10]), .converter_req(req[11]),
    .external_zero_pin(ext_pin), .external_zero_fall(ext_fall), .irq(irq));
  irq_source_model u_irq_source_model (.pclk(pclk), .presetn(presetn),
    .fire(fire), .req(req), .ext_pin(ext_pin));
  // clock and cycle ceiling
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input bus_word_type got, input bus_word_type exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input bus_addr_type a,
                     input bus_word_type d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pulse(input int i);
    fire[i] <= 1'b1;
    @(posedge pclk);
    fire <= 13'h0000;
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 0);
    chk({31'h0, err_seen}, 0);
    apb(0, `OFS_IRQ_MASK, 0); chk(rd, 0);
    apb(1, `OFS_FLAG_STATUS, 32'hffff);
    apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 32'h3fef);
    apb(1, `OFS_FLAG_STATUS, 0);
    apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 0);
    apb(0, 12'h010, 0); chk({31'h0, err_seen}, 1);
    chk(rd, 0);
    $display("test reset done");
  endtask
  task automatic t_sources();
    for (int i = 0; i < 13; i++) begin
      pulse(i);
      apb(0, `OFS_FLAG_STATUS, 0);
      chk(rd, 32'h1 << (i < 12 ? pos[i] : 0));
      apb(1, `OFS_FLAG_STATUS, 0);
      apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 0);
    end
    $display("test sources done");
  endtask
  task automatic t_irq();
    apb(1, `OFS_IRQ_STATUS, 32'hffff);
    pulse(5);
    chk({31'h0, irq}, 0);
    apb(0, `OFS_IRQ_STATUS, 0); chk(rd, 32'h0080);
    apb(1, `OFS_IRQ_MASK, 32'h0080);
    apb(0, `OFS_IRQ_MASK, 0); chk(rd, 32'h0080);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 1);
    apb(1, `OFS_IRQ_STATUS, 32'h0080);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 0);
    $display("test irq done");
  endtask
  // falling polarity: fall sets bit zero, rise is ignored
  task automatic t_ext_fall();
    ext_fall <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1, `OFS_FLAG_STATUS, 0);
    pulse(12);
    apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 32'h1);
    apb(1, `OFS_FLAG_STATUS, 0);
    pulse(12);
    apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 0);
    $display("test falling edge done");
  endtask
  // reset in mid-run wipes flags, status, mask and irq
  task automatic t_midreset();
    pulse(11);
    apb(1, `OFS_IRQ_MASK, 32'h2000);
    chk({31'h0, irq}, 1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, irq}, 0);
    apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 0);
    apb(0, `OFS_IRQ_MASK, 0); chk(rd, 0);
    apb(0, `OFS_IRQ_STATUS, 0); chk(rd, 0);
    pulse(9);
    apb(0, `OFS_FLAG_STATUS, 0); chk(rd, 32'h0800);
    $display("test mid-run reset done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_sources();
    t_irq();
    t_ext_fall();
    t_midreset();
    results();
  end
endmodule
`default_nettype wire
